/* design/serial_tx_defines.svh */
`ifndef SERIAL_TX_DEFINES_SVH
`define SERIAL_TX_DEFINES_SVH

// ----------
// Byte timing (bit clock is ref_clk_i, one serial bit per cycle)
// ----------
`define SERTX_PHASE_LAST 4'h9
`define SERTX_PHASE_FIRST 4'h0
`define SERTX_BYTE_CLK_HIGH 4'h5
`define SERTX_RP_LOW_FIRST 4'h2
`define SERTX_RP_LOW_LAST 4'h6

// ----------
// Register map (byte addresses) and control fields
// ----------
`define SERTX_ADDR_W 12
`define SERTX_ADDR_CTRL 12'h000
`define SERTX_ADDR_STATUS 12'h004
`define SERTX_ADDR_DATA_CNT 12'h008
`define SERTX_ADDR_COMMA_CNT 12'h00c
`define SERTX_ADDR_VIOL_CNT 12'h010
`define SERTX_ADDR_LOOP_CNT 12'h014
`define SERTX_CTRL_BYPASS_BIT 0
`define SERTX_CTRL_BIST_BIT 1
`define SERTX_CTRL_OFF_BIT 2
`define SERTX_STAT_RD_BIT 0
`define SERTX_STAT_BIST_BIT 1
`define SERTX_STAT_COMMA_BIT 2
`define SERTX_CTRL_RESET 3'h0

// ----------
// Code constants
// ----------
`define SERTX_K28_5_BYTE 8'hbc
`define SERTX_VIOL_NEG 10'h278
`define SERTX_VIOL_POS 10'h187
`define SERTX_LFSR_SEED 9'h000
`define SERTX_LFSR_VIOL_STATE 9'h1c0

`endif

/* design/serial_tx_pkg.sv */
package serial_tx_pkg;

    // One character held by the input register
    typedef struct packed {
        logic violation;
        logic special;
        logic [7:0] data;
    } tx_char_t;

    // Software control bits
    typedef struct packed {
        logic output_off;
        logic bist_enable;
        logic bypass;
    } tx_ctrl_t;

    // Source of the input register, Gray coded along normal -> start -> run
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_BIST_START = 2'b01,
        ST_BIST_RUN = 2'b11
    } tx_state_t;

endpackage : serial_tx_pkg

/* design/tx_encoder.sv */
`timescale 1ns/1ns
`include "serial_tx_defines.svh"

// ----------------------------------------------------------------------------
// Combinational 8b/10b encoder; word bit 9 is code bit a
// ----------------------------------------------------------------------------
module tx_encoder (
    input wire serial_tx_pkg::tx_char_t char_i,
    input wire logic comma_i,
    input wire logic bypass_i,
    input wire logic rd_i,
    output logic [9:0] word_o,
    output logic rd_o,
    output logic viol_o
);

    // 5b/6b table, negative running disparity column, abcdei
    function automatic logic [5:0] map6(input logic [4:0] x);
        logic [5:0] c;
        case (x)
            5'd0: c = 6'b100111;  5'd1: c = 6'b011101;  5'd2: c = 6'b101101;
            5'd3: c = 6'b110001;  5'd4: c = 6'b110101;  5'd5: c = 6'b101001;
            5'd6: c = 6'b011001;  5'd7: c = 6'b111000;  5'd8: c = 6'b111001;
            5'd9: c = 6'b100101;  5'd10: c = 6'b010101; 5'd11: c = 6'b110100;
            5'd12: c = 6'b001101; 5'd13: c = 6'b101100; 5'd14: c = 6'b011100;
            5'd15: c = 6'b010111; 5'd16: c = 6'b011011; 5'd17: c = 6'b100011;
            5'd18: c = 6'b010011; 5'd19: c = 6'b110010; 5'd20: c = 6'b001011;
            5'd21: c = 6'b101010; 5'd22: c = 6'b011010; 5'd23: c = 6'b111010;
            5'd24: c = 6'b110011; 5'd25: c = 6'b100110; 5'd26: c = 6'b010110;
            5'd27: c = 6'b110110; 5'd28: c = 6'b001110; 5'd29: c = 6'b101110;
            5'd30: c = 6'b011110; default: c = 6'b101011;
        endcase
        return c;
    endfunction : map6

    // 3b/4b table, negative column, fghj
    function automatic logic [3:0] map4(input logic [2:0] y);
        logic [3:0] c;
        case (y)
            3'd0: c = 4'b1011; 3'd1: c = 4'b1001; 3'd2: c = 4'b0101; 3'd3: c = 4'b1100;
            3'd4: c = 4'b1101; 3'd5: c = 4'b1010; 3'd6: c = 4'b0110; default: c = 4'b1110;
        endcase
        return c;
    endfunction : map4

    function automatic logic [2:0] ones6(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 6; i++) begin
            n = n + {2'b00, v[i]};
        end
        return n;
    endfunction : ones6

    logic [7:0] d;
    logic k, k28, k_ok, bal6, rd6, alt;
    logic [5:0] c6;
    logic [3:0] c4;

    // Comma substitution when nothing was loaded
    assign d = comma_i ? `SERTX_K28_5_BYTE : char_i.data;
    assign k = comma_i | char_i.special;
    assign k28 = k && (d[4:0] == 5'd28);
    assign k_ok = k28 || (d[7:5] == 3'd7 && (d[4:0] == 5'd23 || d[4:0] == 5'd27
                  || d[4:0] == 5'd29 || d[4:0] == 5'd30));

    // Six-bit block: complement under positive disparity when unbalanced or D7
    always_comb begin
        c6 = k28 ? 6'b001111 : map6(d[4:0]);
        bal6 = (ones6(c6) == 3'd3);
        if (rd_i && (!bal6 || d[4:0] == 5'd7)) begin
            c6 = ~c6;
        end
        rd6 = bal6 ? rd_i : ~rd_i;
    end

    // Four-bit block, alternate .7 avoids run lengths of five
    always_comb begin
        alt = (d[7:5] == 3'd7) && (k || (!rd6 && (d[4:0] == 5'd17 || d[4:0] == 5'd18
              || d[4:0] == 5'd20)) || (rd6 && (d[4:0] == 5'd11 || d[4:0] == 5'd13
              || d[4:0] == 5'd14)));
        c4 = alt ? 4'b0111 : map4(d[7:5]);
        if ((rd6 && (d[7:5] == 3'd0 || d[7:5] == 3'd3 || d[7:5] == 3'd4 || d[7:5] == 3'd7))
            || (k28 && !rd6 && (d[7:5] == 3'd1 || d[7:5] == 3'd2 || d[7:5] == 3'd5
            || d[7:5] == 3'd6))) begin
            c4 = ~c4;
        end
    end

    // Output select: bypass, forced or illegal violation, or normal code
    always_comb begin
        viol_o = 1'b0;
        if (bypass_i) begin
            word_o = {char_i.data[0], char_i.data[1], char_i.data[2], char_i.data[3],
                      char_i.data[4], char_i.data[5], char_i.data[6], char_i.data[7],
                      char_i.special, char_i.violation};
            rd_o = rd_i;
        end else if (!comma_i && (char_i.violation || (k && !k_ok))) begin
            word_o = rd_i ? `SERTX_VIOL_POS : `SERTX_VIOL_NEG;
            rd_o = rd_i;
            viol_o = 1'b1;
        end else begin
            word_o = {c6, c4};
            rd_o = (d[7:5] == 3'd0 || d[7:5] == 3'd4 || d[7:5] == 3'd7) ? ~rd6 : rd6;
        end
    end

endmodule : tx_encoder

/* design/tx_shifter.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Ten-bit serialiser with three registered line outputs
// ----------------------------------------------------------------------------
module tx_shifter (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [9:0] word_i,
    input wire logic off_i,
    output logic first_o,
    output logic second_o,
    output logic loop_o
);

    logic [9:0] shift;
    logic next_bit;

    // Bit a leaves first, one bit per clock
    assign next_bit = load_i ? word_i[9] : shift[9];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shift <= 10'h000;
        end else if (load_i) begin
            shift <= {word_i[8:0], 1'b0};
        end else begin
            shift <= {shift[8:0], 1'b0};
        end
    end

    // Gating is not aligned to bytes, so a word may be cut mid-way
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            first_o <= 1'b0;
            second_o <= 1'b0;
            loop_o <= 1'b0;
        end else begin
            first_o <= next_bit & ~off_i;
            second_o <= next_bit & ~off_i;
            loop_o <= next_bit;
        end
    end

endmodule : tx_shifter

/* design/serial_8b10b_transmitter.sv */
// Operation
// - Each byte tick the input register takes data, special flag and violation bit.
// - Immediate load enable low at a tick loads the inputs at that tick.
// - Next load enable low at a tick loads the inputs at the following tick.
// - With no enable asserted, that byte time carries the K28.5 comma; in bypass the code resends the held register bits unencoded instead.
// - Self-test turns the input register into a 511-state pseudo-random generator.
// - Special flag selects the control code table, otherwise the data table.
// - Violation bit replaces the encoding with a fixed code-violation symbol.
// - Bypass mode sends the ten input bits unencoded as one word.
// - In bypass, bit a is shifted out first, then code order.
// - Shifter loads one word per byte time and sends ten bits.
// - Shifter load timing comes only from the internal byte counter.
// - All three lines carry one stream; output-off forces the first two low.
// - The loopback line ignores output-off and always carries the stream.
// - Output-off acts within bit times, regardless of byte boundaries.
// - A byte-rate read pulse from the byte counter feeds asynchronous FIFOs.
// - Read pulse width and phase depend only on the internal counter.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "serial_tx_defines.svh"

module serial_8b10b_transmitter #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`SERTX_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] parallel_byte_in_i,
    input wire logic special_char_flag_i,
    input wire logic violation_force_i,
    input wire logic load_enable_now_n_i,
    input wire logic load_enable_next_n_i,
    output logic byte_clock_o,
    output logic fifo_read_pulse_n_o,
    output logic serial_drive_first_o,
    output logic serial_drive_second_o,
    output logic serial_drive_loopback_o
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("CNT_W must lie between 1 and 32");
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    serial_tx_pkg::tx_ctrl_t ctrl;
    serial_tx_pkg::tx_state_t state;
    serial_tx_pkg::tx_state_t next_state;
    serial_tx_pkg::tx_char_t char_q;
    serial_tx_pkg::tx_char_t next_char;
    logic [3:0] phase;
    logic byte_tick;
    logic enn_pending;
    logic load_now;
    logic comma_q;
    logic [8:0] lfsr;
    logic [8:0] next_lfsr;
    logic rd;
    logic enc_rd;
    logic enc_viol;
    logic [9:0] enc_word;
    logic [CNT_W-1:0] data_cnt;
    logic [CNT_W-1:0] comma_cnt;
    logic [CNT_W-1:0] viol_cnt;
    logic [CNT_W-1:0] loop_cnt;
    logic apb_setup;
    logic apb_write;
    logic [31:0] status;
    logic [32:0] rd_word;

    // Counter step shared by the statistics registers
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v,
                                              input logic inc,
                                              input logic clr);
        logic [CNT_W-1:0] r;
        r = clr ? {CNT_W{1'b0}} : v;
        if (inc) begin
            r = r + CNT_W'(1);
        end
        return r;
    endfunction : bump

    // Address decode for reads; unmapped offsets report an error
    function automatic logic [32:0] read_word(input logic [`SERTX_ADDR_W-1:0] a,
                                              input logic [32*4-1:0] cnts,
                                              input logic [31:0] ctl,
                                              input logic [31:0] st);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (a == `SERTX_ADDR_CTRL) begin
            r[31:0] = ctl;
        end else if (a == `SERTX_ADDR_STATUS) begin
            r[31:0] = st;
        end else if (a == `SERTX_ADDR_DATA_CNT) begin
            r[31:0] = cnts[31:0];
        end else if (a == `SERTX_ADDR_COMMA_CNT) begin
            r[31:0] = cnts[63:32];
        end else if (a == `SERTX_ADDR_VIOL_CNT) begin
            r[31:0] = cnts[95:64];
        end else if (a == `SERTX_ADDR_LOOP_CNT) begin
            r[31:0] = cnts[127:96];
        end else begin
            r[32] = 1'b1;
        end
        return r;
    endfunction : read_word

    // ------------------------------------------------------------------------
    // Byte counter and byte-rate outputs
    // ------------------------------------------------------------------------

    // Free-running ten-cycle byte timer; nothing on the pins moves it
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || phase == `SERTX_PHASE_LAST) begin
            phase <= `SERTX_PHASE_FIRST;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    assign byte_tick = (phase == `SERTX_PHASE_LAST);

    // Read pulse and byte clock decoded from the counter only, never from inputs
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fifo_read_pulse_n_o <= 1'b1;
            byte_clock_o <= 1'b0;
        end else begin
            fifo_read_pulse_n_o <= !(phase >= `SERTX_RP_LOW_FIRST
                                     && phase <= `SERTX_RP_LOW_LAST);
            byte_clock_o <= (phase < `SERTX_BYTE_CLK_HIGH);
        end
    end

    // ------------------------------------------------------------------------
    // Input register: normal loading or self-test generator
    // ------------------------------------------------------------------------

    // Next-cycle enable is remembered for exactly one byte tick
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            enn_pending <= 1'b0;
        end else if (byte_tick) begin
            enn_pending <= !load_enable_next_n_i;
        end
    end

    assign load_now = !load_enable_now_n_i || enn_pending;

    // XNOR feedback keeps the all-zero seed legal; all-ones is never reached
    assign next_lfsr = {lfsr[7:0], ~(lfsr[8] ^ lfsr[4])};

    // Source selection for the input register
    always_comb begin
        next_state = serial_tx_pkg::ST_NORMAL;
        case (state)
            serial_tx_pkg::ST_NORMAL: begin
                if (ctrl.bist_enable) begin
                    next_state = serial_tx_pkg::ST_BIST_START;
                end
            end
            default: begin
                if (ctrl.bist_enable) begin
                    next_state = serial_tx_pkg::ST_BIST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= serial_tx_pkg::ST_NORMAL;
        end else if (byte_tick) begin
            state <= next_state;
        end
    end

    // Generator restarts from the seed on every entry, so loops are repeatable
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lfsr <= `SERTX_LFSR_SEED;
        end else if (byte_tick) begin
            if (next_state == serial_tx_pkg::ST_BIST_START) begin
                lfsr <= `SERTX_LFSR_SEED;
            end else if (next_state == serial_tx_pkg::ST_BIST_RUN) begin
                lfsr <= next_lfsr;
            end
        end
    end

    // Character chosen for the next byte time
    always_comb begin
        next_char = char_q;
        if (next_state != serial_tx_pkg::ST_NORMAL) begin
            next_char.data = (next_state == serial_tx_pkg::ST_BIST_START)
                             ? 8'(`SERTX_LFSR_SEED) : next_lfsr[7:0];
            next_char.special = (next_state == serial_tx_pkg::ST_BIST_START)
                                ? 1'b0 : next_lfsr[8];
            next_char.violation = (next_state == serial_tx_pkg::ST_BIST_RUN)
                                  && (next_lfsr == `SERTX_LFSR_VIOL_STATE);
        end else if (load_now) begin
            next_char.data = parallel_byte_in_i;
            next_char.special = special_char_flag_i;
            next_char.violation = violation_force_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            char_q <= '0;
            comma_q <= 1'b1;
        end else if (byte_tick) begin
            char_q <= next_char;
            comma_q <= (next_state == serial_tx_pkg::ST_NORMAL) && !load_now;
        end
    end

    // ------------------------------------------------------------------------
    // Encoder, disparity and shifter
    // ------------------------------------------------------------------------
    tx_encoder u_encoder (
        .char_i(char_q),
        .comma_i(comma_q),
        .bypass_i(ctrl.bypass),
        .rd_i(rd),
        .word_o(enc_word),
        .rd_o(enc_rd),
        .viol_o(enc_viol)
    );

    // Disparity advances only when a word is handed to the shifter
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd <= 1'b0;
        end else if (byte_tick) begin
            rd <= enc_rd;
        end
    end

    tx_shifter u_shifter (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .load_i(byte_tick),
        .word_i(enc_word),
        .off_i(ctrl.output_off),
        .first_o(serial_drive_first_o),
        .second_o(serial_drive_second_o),
        .loop_o(serial_drive_loopback_o)
    );

    // ------------------------------------------------------------------------
    // APB slave: zero wait states, read data captured in the setup cycle
    // ------------------------------------------------------------------------
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl <= `SERTX_CTRL_RESET;
        end else if (apb_write && paddr_i == `SERTX_ADDR_CTRL) begin
            ctrl.bypass <= pwdata_i[`SERTX_CTRL_BYPASS_BIT];
            ctrl.bist_enable <= pwdata_i[`SERTX_CTRL_BIST_BIT];
            ctrl.output_off <= pwdata_i[`SERTX_CTRL_OFF_BIT];
        end
    end

    // Statistics; an event in the clearing cycle still counts
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            data_cnt <= '0;
            comma_cnt <= '0;
            viol_cnt <= '0;
            loop_cnt <= '0;
        end else begin
            data_cnt <= bump(data_cnt, byte_tick && !comma_q,
                             apb_write && paddr_i == `SERTX_ADDR_DATA_CNT);
            comma_cnt <= bump(comma_cnt, byte_tick && comma_q,
                              apb_write && paddr_i == `SERTX_ADDR_COMMA_CNT);
            viol_cnt <= bump(viol_cnt, byte_tick && enc_viol,
                             apb_write && paddr_i == `SERTX_ADDR_VIOL_CNT);
            loop_cnt <= bump(loop_cnt, byte_tick && state == serial_tx_pkg::ST_BIST_RUN
                             && next_lfsr == `SERTX_LFSR_SEED,
                             apb_write && paddr_i == `SERTX_ADDR_LOOP_CNT);
        end
    end

    // Read data and error latched at setup, stable through the access phase
    always_comb begin
        status = 32'h0000_0000;
        status[`SERTX_STAT_RD_BIT] = rd;
        status[`SERTX_STAT_BIST_BIT] = (state != serial_tx_pkg::ST_NORMAL);
        status[`SERTX_STAT_COMMA_BIT] = comma_q;
        rd_word = read_word(paddr_i, {32'(loop_cnt), 32'(viol_cnt), 32'(comma_cnt),
                            32'(data_cnt)}, {29'h0, ctrl}, status);
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (apb_setup) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word[31:0];
            pslverr_o <= rd_word[32];
        end
    end

endmodule : serial_8b10b_transmitter

/* tb/serial_tx_checker.sv */
`timescale 1ns/1ns
`include "serial_tx_defines.svh"

module serial_tx_checker (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`SERTX_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic byte_clock_o,
    input wire logic fifo_read_pulse_n_o,
    input wire logic serial_drive_first_o,
    input wire logic serial_drive_second_o,
    input wire logic serial_drive_loopback_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic off_q;
    wire logic al = paddr_i[1:0] == 2'h0;
    wire logic bad = al && paddr_i > `SERTX_ADDR_LOOP_CNT;
    wire logic good = al && paddr_i <= `SERTX_ADDR_LOOP_CNT;
    // Output-off copy, kept here because the control bit is not a port
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            off_q <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i == `SERTX_ADDR_CTRL) begin
            off_q <= pwdata_i[`SERTX_CTRL_OFF_BIT];
        end
    end
    sequence bc_hi_s; byte_clock_o [*5]; endsequence
    sequence bc_lo_s; !byte_clock_o [*5]; endsequence
    sequence rp_lo_s; !fifo_read_pulse_n_o [*5]; endsequence
    sequence rp_hi_s; fifo_read_pulse_n_o [*5]; endsequence
    AST_BYTE_CLK: assert property ($rose(byte_clock_o) |-> bc_hi_s ##1 bc_lo_s ##1 byte_clock_o)
        else $error("byte clock period wrong");
    AST_READ_PULSE: assert property ($fell(fifo_read_pulse_n_o) |-> rp_lo_s ##1 rp_hi_s)
        else $error("read pulse shape wrong");
    AST_LINES_SAME: assert property (serial_drive_first_o == serial_drive_second_o)
        else $error("first and second lines differ");
    AST_OFF_LOW: assert property (off_q |=> !serial_drive_first_o)
        else $error("gated line not forced low");
    AST_ON_STREAM: assert property (!off_q && !$past(off_q) |-> serial_drive_first_o == serial_drive_loopback_o)
        else $error("lines carry different streams");
    AST_LOOP_LIVE: assert property ($rose(off_q) |-> ##[1:40] serial_drive_loopback_o)
        else $error("loopback line stopped");
    AST_UNMAPPED: assert property (psel_i && !penable_i && bad |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (psel_i && !penable_i && good |=> !pslverr_o && pready_o)
        else $error("mapped access refused");
endmodule : serial_tx_checker

bind serial_8b10b_transmitter serial_tx_checker u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .byte_clock_o(byte_clock_o), .fifo_read_pulse_n_o(fifo_read_pulse_n_o),
    .serial_drive_first_o(serial_drive_first_o), .serial_drive_second_o(serial_drive_second_o),
    .serial_drive_loopback_o(serial_drive_loopback_o));

/* tb/fifo_source_model.sv */
`timescale 1ns/1ns

// ----------
// Byte source: mode 0 idle, 1 load now, 2 load next
// ----------
module fifo_source_model (
    input wire logic ref_clk_i,
    input wire logic [1:0] mode_i,
    input wire serial_tx_pkg::tx_char_t char_i,
    output serial_tx_pkg::tx_char_t char_o = 10'h000,
    output logic now_n_o = 1'b1,
    output logic next_n_o = 1'b1
);
    logic [9:0] pat = 10'h000;
    // Idle data wanders every cycle so a stray load shows up
    always @(posedge ref_clk_i) begin
        pat <= pat + 10'h001;
        now_n_o <= mode_i != 2'h1;
        next_n_o <= mode_i != 2'h2;
        char_o <= (mode_i == 2'h0) ? pat : char_i;
    end
endmodule : fifo_source_model

/* tb/serial_8b10b_transmitter_tb_top.sv */
`timescale 1ns/1ns
`include "serial_tx_defines.svh"

module serial_8b10b_transmitter_tb_top;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, pready, bclk, rp_n, s1, s2, sl, nw, nx;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [1:0] mode = 2'h0;
    serial_tx_pkg::tx_char_t ch = 10'h000, src;
    int fails = 0, n_checks = 0, cyc = 0;
    serial_8b10b_transmitter u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(err), .parallel_byte_in_i(src.data),
        .special_char_flag_i(src.special), .violation_force_i(src.violation),
        .load_enable_now_n_i(nw), .load_enable_next_n_i(nx), .byte_clock_o(bclk),
        .fifo_read_pulse_n_o(rp_n), .serial_drive_first_o(s1), .serial_drive_second_o(s2),
        .serial_drive_loopback_o(sl));
    fifo_source_model u_src (.ref_clk_i(ref_clk_i), .mode_i(mode), .char_i(ch),
        .char_o(src), .now_n_o(nw), .next_n_o(nx));
    // ----------
    // Clock, cycle counter from release, watchdog
    // ----------
    initial forever #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (!srst_i) cyc <= cyc + 1;
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    task automatic end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        r = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Words start at edge counts divisible by ten; bit a lands in w[9]
    task automatic get_word(output logic [9:0] w);
        #1;
        while (cyc % 10 != 0) begin
            @(posedge ref_clk_i);
            #1;
        end
        for (int k = 9; k >= 0; k--) begin
            w[k] = sl;
            @(posedge ref_clk_i);
            #1;
        end
    endtask : get_word
    task automatic t_regs;
        apb(1'b0, `SERTX_ADDR_CTRL, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, `SERTX_ADDR_DATA_CNT, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, 12'h040, 32'hffffffff);
        chk(32'(err), 32'h1);
    endtask : t_regs
    // Early words are stale while a new setting reaches the line
    task automatic t_code(input logic [1:0] m, input serial_tx_pkg::tx_char_t c,
                          input logic [9:0] a, input logic [9:0] b, input logic alt);
        logic [9:0] w1, w2;
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h0);
        mode <= m;
        ch <= c;
        repeat (4) get_word(w1);
        get_word(w2);
        chk(32'(w1 == a || w1 == b), 32'h1);
        chk(32'(w2 ^ w1), alt ? 32'h3ff : 32'h0);
    endtask : t_code
    task automatic t_bypass(input logic [1:0] m, input serial_tx_pkg::tx_char_t c);
        logic [9:0] w, e;
        for (int k = 0; k < 8; k++) e[9-k] = c.data[k];
        e[1] = c.special;
        e[0] = c.violation;
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h1);
        mode <= m;
        ch <= c;
        repeat (5) get_word(w);
        chk(32'(w), 32'(e));
    endtask : t_bypass
    task automatic t_off;
        logic [31:0] on1 = 0, onl = 0;
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h4);
        repeat (3) @(negedge ref_clk_i);
        repeat (30) begin
            @(negedge ref_clk_i);
            on1 += s1 | s2;
            onl += sl;
        end
        chk(on1, 0);
        chk(32'(onl > 0), 32'h1);
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h0);
    endtask : t_off
    task automatic t_bist;
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h2);
        repeat (5200) @(posedge ref_clk_i);
        apb(1'b0, `SERTX_ADDR_STATUS, 32'h0);
        chk(32'(r[`SERTX_STAT_BIST_BIT]), 32'h1);
        apb(1'b0, `SERTX_ADDR_LOOP_CNT, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, `SERTX_ADDR_CTRL, 32'h0);
    endtask : t_bist
    initial begin
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_code(2'h0, 10'h000, 10'h0fa, 10'h305, 1'b1);
        t_code(2'h1, 10'h1bc, 10'h0fa, 10'h305, 1'b1);
        t_code(2'h1, 10'h000, 10'h274, 10'h18b, 1'b0);
        t_code(2'h2, 10'h000, 10'h274, 10'h18b, 1'b0);
        t_code(2'h1, 10'h200, 10'h278, 10'h187, 1'b0);
        t_bypass(2'h1, 10'h235);
        t_bypass(2'h2, 10'h1c6);
        t_off();
        t_bist();
        end_sim();
    end
endmodule : serial_8b10b_transmitter_tb_top
